// file: ngp_arb.sv
// picks the highest ranked pending unmasked request
`default_nettype none
module ngp_arb (
    ngp_req_if.arb ri
);
    import ngp_pkg::*;

    // slot is group rank in the upper pair, fixed in-group place below
    function automatic logic [3:0] ngp_slot(input logic [7:0] rank,
        input int unsigned s);
        ngp_slot = {rank[(s / 4) * 2 +: 2], 2'(s % 4)};
    endfunction

    logic [3:0] slot [15];
    ngp_src_t live;

    assign live = ri.hold & ~ri.mask;

    genvar i;
    generate
        for (i = 0; i < 15; i++) begin : g_slot
            assign slot[i] = ngp_slot(ri.rank, i);
        end
    endgenerate

    always_comb begin
        ri.cand = 1'b0;
        ri.cand_slot = 4'h0;
        ri.cand_src = 4'h0;
        for (int k = 0; k < 15; k++) begin
            if (live[k] && (!ri.cand || slot[k] > ri.cand_slot)) begin
                ri.cand = 1'b1;
                ri.cand_slot = slot[k];
                ri.cand_src = 4'(k);
            end
        end
    end
endmodule
`default_nettype wire

// file: ngp_consts.svh
// constants of the grouped interrupt priority controller
`ifndef NGP_CONSTS_SVH
`define NGP_CONSTS_SVH
`define NGP_OFF_RANK 8'h00
`define NGP_OFF_CLR 8'h04
`define NGP_OFF_HOLD 8'h08
`define NGP_OFF_MASK 8'h0c
`define NGP_OFF_MODE 8'h10
`define NGP_OFF_CTRL 8'h14
`define NGP_OFF_STAT 8'h18
`define NGP_RANK_RST 8'he4
`define NGP_MASK_RST 15'h7fff
`define NGP_PIN_SRC 15'h1177
`define NGP_CODE_BASE 16'hfe00
`define NGP_VEC_BASE0 32'hfffffe00
`define NGP_VEC_BASE1 32'hfe000000
`define NGP_NMI_CODE 16'hffd0
`define NGP_NMI_VEC 32'hffffffd0
`define NGP_NSRC 15
`endif

// file: ngp_cpu_model.sv
// cpu side model: return pc, status loads and trap returns
`default_nettype none
module ngp_cpu_model (
    input wire logic clk,
    output logic [31:0] cpu_pc,
    output logic return_from_trap,
    output logic fatal_return,
    output logic sysreg_load,
    output ngp_pkg::ngp_status_t sysreg_status
);
    timeunit 1ns;
    timeprecision 1ns;
    import ngp_pkg::*;

    // ==========================================================
    // idle levels
    initial begin
        cpu_pc = 32'h0;
        return_from_trap = 1'b0;
        fatal_return = 1'b0;
        sysreg_load = 1'b0;
        sysreg_status = 7'h00;
    end

    // ==========================================================
    // return pc presented at the next entry
    task automatic set_pc(input logic [31:0] v);
        @(posedge clk);
        cpu_pc <= v;
    endtask

    // ==========================================================
    // kind 0 status load, 1 normal return, 2 fatal return
    task automatic pulse(input int kind, input ngp_status_t st);
        @(posedge clk);
        sysreg_status <= st;
        sysreg_load <= (kind == 0);
        return_from_trap <= (kind == 1);
        fatal_return <= (kind == 2);
        @(posedge clk);
        sysreg_load <= 1'b0;
        return_from_trap <= 1'b0;
        fatal_return <= 1'b0;
        // released status lines show no stale value
        sysreg_status <= ~st;
    endtask
endmodule
`default_nettype wire

// file: ngp_pkg.sv
// types shared by the grouped interrupt priority controller
`default_nettype none
package ngp_pkg;
    typedef logic [14:0] ngp_src_t;
    typedef struct packed {
        logic np;
        logic ep;
        logic id;
        logic [3:0] lvl;
    } ngp_status_t;
endpackage
`default_nettype wire

// file: ngp_req_if.sv
// request hold and arbitration signals between the controller parts
`default_nettype none
interface ngp_req_if;
    import ngp_pkg::*;
    ngp_src_t hold;
    ngp_src_t mask;
    ngp_src_t mode;
    ngp_src_t clr_bits;
    logic clr_wr;
    logic acc;
    logic [3:0] acc_src;
    logic [7:0] rank;
    logic cand;
    logic [3:0] cand_slot;
    logic [3:0] cand_src;
    modport sns(input mode, clr_wr, clr_bits, acc, acc_src, output hold);
    modport arb(input hold, mask, rank, output cand, cand_slot, cand_src);
    modport ctl(output mode, mask, rank, clr_wr, clr_bits, acc, acc_src,
        input hold, cand, cand_slot, cand_src);
endinterface
`default_nettype wire

// file: ngp_sense.sv
// request capture: edge or level sensing and held requests
`default_nettype none
`include "ngp_consts.svh"
module ngp_sense (
    input wire logic clk,
    input wire logic reset,
    input wire ngp_pkg::ngp_src_t src,
    ngp_req_if.sns ri
);
    import ngp_pkg::*;
    typedef struct packed {
        ngp_src_t prev;
        ngp_src_t hold;
    } ngp_sense_st_t;
    ngp_sense_st_t q;
    ngp_sense_st_t d;
    ngp_src_t lvl;
    ngp_src_t rise;
    ngp_src_t clr_eff;
    ngp_src_t clr_only;

    // on-chip sources stay edge whatever the mode bit says
    assign lvl = ri.mode & `NGP_PIN_SRC;
    assign rise = src & ~q.prev;
    assign clr_only = clr_eff & ~rise;

    genvar i;
    generate
        for (i = 0; i < `NGP_NSRC; i++) begin : g_src
            assign clr_eff[i] = ~lvl[i] & ((ri.clr_wr & ri.clr_bits[i]) |
                (ri.acc & (ri.acc_src == 4'(i))));
        end
    endgenerate

    always_comb begin
        d = q;
        d.prev = src;
        // a new edge wins over a clear in the same cycle
        d.hold = (lvl & src) | (~lvl & ((q.hold & ~clr_eff) | rise));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ri.hold = q.hold;

    AST_EDGE_CLR: assert property (@(posedge clk) disable iff (reset)
        (|clr_only) |=> ((q.hold & $past(clr_only)) == '0))
        else $error("cleared edge request still held");
endmodule
`default_nettype wire

// file: ngp_top.sv
// non-maskable and grouped maskable interrupt acceptance unit
//
// How it works
// - non-maskable request taken despite disable, above all, ignores group ranks
// - non-maskable request waits while busy flag set, taken once cleared
// - non-maskable entry saves pc and status into fatal save registers
// - fifteen maskable sources, each with its own mask bit
// - simultaneous maskable requests are taken one at a time by priority
// - maskable taking blocked by busy, exception-hold or disable flag
// - request level below accept level is refused; level 15 never
// - maskable entry sets disable and exception-hold, accept level n+1, level 15 stays 15
// - maskable entry saves pc and status into interrupt save registers
// - masked or blocked requests stay pending until allowed
// - four groups, three of four and the last of three; fixed order inside, ranked between groups
// - on-chip sources edge only; pin sources edge or level
// - rank register holds four 2-bit rank fields, 11 highest
// - code fe00 plus 16 per slot; handler at either vector base
// - normal return for all but fatal; fatal uses the fatal return
// - clear bit drops held edge request; level not cleared; reads 0
// - rank register resets to e4 for the standard slot mapping
// - mask bit 1 blocks its source; all masks reset to 1
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`default_nettype none
`include "ngp_consts.svh"
module ngp_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire ngp_pkg::ngp_src_t src_req,
    input wire logic nmi_pin_n,
    input wire logic nmi_int,
    input wire logic [31:0] cpu_pc,
    input wire logic return_from_trap,
    input wire logic fatal_return,
    input wire logic sysreg_load,
    input wire ngp_pkg::ngp_status_t sysreg_status,
    output logic take_valid,
    output logic take_nmi,
    output logic [15:0] take_code,
    output logic [31:0] take_addr,
    output logic [31:0] fatal_save_pc,
    output ngp_pkg::ngp_status_t fatal_save_status,
    output logic [31:0] irq_save_pc,
    output ngp_pkg::ngp_status_t irq_save_status,
    output ngp_pkg::ngp_status_t status,
    output logic offer_valid,
    output logic [3:0] offer_level,
    output logic [15:0] offer_code
);
    import ngp_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [7:0] rank;
        ngp_src_t mask;
        ngp_src_t mode;
        logic vbase;
        ngp_status_t st;
        logic [31:0] fpc;
        ngp_status_t fst;
        logic [31:0] ipc;
        ngp_status_t ist;
        logic nmi_pend;
        logic nmi_pin_q;
        logic [31:0] rdata;
        logic take;
        logic take_nmi;
        logic [15:0] code;
        logic [31:0] addr;
        logic ovalid;
        logic [3:0] olevel;
        logic [15:0] ocode;
    } ngp_top_st_t;

    ngp_top_st_t q;
    ngp_top_st_t d;
    logic nmi_edge;
    logic cpu_evt;
    logic irq_block;
    logic lvl_ok;
    logic nmi_go;
    logic irq_go;

    ngp_req_if ri ();

    function automatic logic [15:0] ngp_code(input logic [3:0] slot);
        ngp_code = `NGP_CODE_BASE + {8'h00, slot, 4'h0};
    endfunction

    // ==========================================================
    // request capture and arbitration
    // ==========================================================
    ngp_sense u_sense (
        .clk(clk),
        .reset(reset),
        .src(src_req),
        .ri(ri.sns)
    );

    ngp_arb u_arb (
        .ri(ri.arb)
    );

    assign ri.mask = q.mask;
    assign ri.mode = q.mode;
    assign ri.rank = q.rank;
    assign ri.clr_wr = reg_wr && (reg_addr == `NGP_OFF_CLR);
    assign ri.clr_bits = reg_wdata[14:0];
    assign ri.acc = irq_go;
    assign ri.acc_src = ri.cand_src;

    // ==========================================================
    // acceptance decisions
    // ==========================================================
    // falling pin edge or internal pulse raises the pending flag
    assign nmi_edge = (q.nmi_pin_q & ~nmi_pin_n) | nmi_int;
    // a status change by the cpu takes the cycle; entry waits one
    assign cpu_evt = return_from_trap | fatal_return | sysreg_load;
    assign irq_block = q.st.np | q.st.ep | q.st.id;
    assign lvl_ok = ri.cand_slot >= q.st.lvl;
    assign nmi_go = q.nmi_pend & ~q.st.np & ~cpu_evt;
    assign irq_go = ri.cand & ~irq_block & lvl_ok & ~nmi_go &
        ~cpu_evt;

    always_comb begin
        d = q;
        d.take = 1'b0;
        d.take_nmi = 1'b0;
        d.nmi_pin_q = nmi_pin_n;
        d.nmi_pend = nmi_edge | (q.nmi_pend & ~nmi_go);

        // status updates from the cpu
        if (sysreg_load) begin
            d.st = sysreg_status;
        end else if (fatal_return) begin
            d.st = q.fst;
        end else if (return_from_trap) begin
            d.st = q.st.np ? q.fst : q.ist;
        end

        // non-maskable entry
        if (nmi_go) begin
            d.fpc = cpu_pc;
            d.fst = q.st;
            d.st.np = 1'b1;
            d.st.id = 1'b1;
            d.take = 1'b1;
            d.take_nmi = 1'b1;
            d.code = `NGP_NMI_CODE;
            d.addr = `NGP_NMI_VEC;
        end

        // maskable entry
        if (irq_go) begin
            d.ipc = cpu_pc;
            d.ist = q.st;
            d.st.id = 1'b1;
            d.st.ep = 1'b1;
            if (ri.cand_slot == 4'hf) begin
                d.st.lvl = 4'hf;
            end else begin
                d.st.lvl = ri.cand_slot + 4'h1;
            end
            d.take = 1'b1;
            d.code = ngp_code(ri.cand_slot);
            d.addr = (q.vbase ? `NGP_VEC_BASE1 : `NGP_VEC_BASE0) +
                {24'h000000, ri.cand_slot, 4'h0};
        end

        // offer of the best pending request
        d.ovalid = ri.cand;
        d.olevel = ri.cand_slot;
        d.ocode = ngp_code(ri.cand_slot);

        // ======================================================
        // register writes
        // ======================================================
        if (reg_wr) begin
            unique case (reg_addr)
                `NGP_OFF_RANK: begin
                    d.rank = reg_wdata[7:0];
                end
                `NGP_OFF_MASK: begin
                    d.mask = reg_wdata[14:0];
                end
                `NGP_OFF_MODE: begin
                    // on-chip sources keep a cleared mode bit
                    d.mode = reg_wdata[14:0] & `NGP_PIN_SRC;
                end
                `NGP_OFF_CTRL: begin
                    d.vbase = reg_wdata[0];
                end
                default: begin
                end
            endcase
        end

        // ======================================================
        // register reads, data valid in the next cycle only
        // ======================================================
        d.rdata = 32'h00000000;
        if (reg_rd) begin
            unique case (reg_addr)
                `NGP_OFF_RANK: begin
                    d.rdata = {24'h000000, q.rank};
                end
                `NGP_OFF_HOLD: begin
                    d.rdata = {17'h0, ri.hold};
                end
                `NGP_OFF_MASK: begin
                    d.rdata = {16'h0000, 1'b1, q.mask};
                end
                `NGP_OFF_MODE: begin
                    d.rdata = {17'h0, q.mode};
                end
                `NGP_OFF_CTRL: begin
                    d.rdata = {31'h0, q.vbase};
                end
                `NGP_OFF_STAT: begin
                    d.rdata = {24'h000000, q.nmi_pend, q.st};
                end
                default: begin
                    d.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.rank <= `NGP_RANK_RST;
            q.mask <= `NGP_MASK_RST;
            q.nmi_pin_q <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign reg_rdata = q.rdata;
    assign take_valid = q.take;
    assign take_nmi = q.take_nmi;
    assign take_code = q.code;
    assign take_addr = q.addr;
    assign fatal_save_pc = q.fpc;
    assign fatal_save_status = q.fst;
    assign irq_save_pc = q.ipc;
    assign irq_save_status = q.ist;
    assign status = q.st;
    assign offer_valid = q.ovalid;
    assign offer_level = q.olevel;
    assign offer_code = q.ocode;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_nmi_go;
        q.nmi_pend && !q.st.np && !cpu_evt;
    endsequence

    sequence s_irq_take;
        q.take && !q.take_nmi;
    endsequence

    AST_NMI_TAKE: assert property (
        s_nmi_go |=> (q.take_nmi && q.addr == `NGP_NMI_VEC))
        else $error("pending nmi not taken");

    AST_NMI_WAIT: assert property (
        q.st.np |=> !q.take_nmi)
        else $error("nmi taken while busy");

    AST_FATAL_SAVE: assert property (
        s_nmi_go |=> (q.fpc == $past(cpu_pc) && q.st.np))
        else $error("fatal save wrong");

    AST_IRQ_BLOCK: assert property (
        (q.st.np || q.st.ep || q.st.id) |=> !(q.take && !q.take_nmi))
        else $error("maskable taken while blocked");

    AST_IRQ_LEVEL: assert property (
        s_irq_take |-> (q.code[7:4] >= $past(q.st.lvl)))
        else $error("level below accept level taken");

    AST_IRQ_FLAGS: assert property (
        s_irq_take |-> (q.st.id && q.st.ep &&
        q.st.lvl == ((q.code[7:4] == 4'hf) ? 4'hf : q.code[7:4] + 4'h1)))
        else $error("flags or level not set on entry");

    AST_IRQ_SAVE: assert property (
        s_irq_take |-> (q.ipc == $past(cpu_pc)))
        else $error("interrupt save wrong");

    AST_ONE_AT_A_TIME: assert property (
        s_irq_take |=> !(q.take && !q.take_nmi))
        else $error("two maskable entries back to back");

    AST_RESET_VALUES: assert property (
        $fell(reset) |-> (q.rank == `NGP_RANK_RST && q.mask == `NGP_MASK_RST))
        else $error("rank or mask reset value wrong");
endmodule
`default_nettype wire

// file: nmi_and_grouped_irq_priority_tb.sv
// self-checking bench of the grouped interrupt priority unit
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module nmi_and_grouped_irq_priority_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ngp_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    ngp_src_t src_req = '0;
    logic nmi_pin_n = 1'b1;
    logic nmi_int = 1'b0;
    logic [31:0] cpu_pc, take_addr, fatal_save_pc, irq_save_pc;
    logic return_from_trap, fatal_return, sysreg_load;
    ngp_status_t sysreg_status, status, fatal_save_status, irq_save_status;
    logic take_valid, take_nmi, offer_valid;
    logic [15:0] take_code, offer_code;
    logic [3:0] offer_level;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;

    always #25 clk = ~clk;

    ngp_cpu_model cpu_u (.clk(clk), .cpu_pc(cpu_pc),
        .return_from_trap(return_from_trap), .fatal_return(fatal_return),
        .sysreg_load(sysreg_load), .sysreg_status(sysreg_status));

    ngp_top dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_req(src_req), .nmi_pin_n(nmi_pin_n),
        .nmi_int(nmi_int), .cpu_pc(cpu_pc),
        .return_from_trap(return_from_trap), .fatal_return(fatal_return),
        .sysreg_load(sysreg_load), .sysreg_status(sysreg_status),
        .take_valid(take_valid), .take_nmi(take_nmi),
        .take_code(take_code), .take_addr(take_addr),
        .fatal_save_pc(fatal_save_pc),
        .fatal_save_status(fatal_save_status),
        .irq_save_pc(irq_save_pc), .irq_save_status(irq_save_status),
        .status(status), .offer_valid(offer_valid),
        .offer_level(offer_level), .offer_code(offer_code));

    // ==========================================================
    // bus and stimulus helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        `CHK(reg_rdata, e)
    endtask

    task automatic drive(input int i, input logic v);
        @(posedge clk);
        src_req[i] <= v;
    endtask

    // waits a bounded time for an entry and checks its kind and code
    task automatic take_chk(input logic nmi, input logic [15:0] code);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (take_valid !== 1'b1 && n < 20);
        `CHK(take_valid, 1'b1)
        `CHK(take_nmi, nmi)
        `CHK(take_code, code)
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clk);
            `CHK(take_valid, 1'b0)
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd_chk(8'h00, 32'he4);
        rd_chk(8'h0c, 32'hffff);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h40, 32'h0);
        `CHK(offer_valid, 1'b0)
        wr(8'h10, 32'h7fff);
        rd_chk(8'h10, 32'h1177);
        wr(8'h10, 32'h0);
    endtask

    task automatic t_single();
        cpu_u.set_pc(32'h12345670);
        wr(8'h0c, 32'h0);
        drive(0, 1'b1);
        take_chk(1'b0, 16'hfe00);
        `CHK(take_addr, 32'hfffffe00)
        `CHK(status, 7'h31)
        `CHK(irq_save_pc, 32'h12345670)
        `CHK(irq_save_status, 7'h00)
        drive(5, 1'b1);
        quiet(8);
        `CHK(offer_code, 16'hfe50)
        `CHK(offer_level, 4'h5)
        `CHK(offer_valid, 1'b1)
        cpu_u.pulse(0, 7'h00);
        take_chk(1'b0, 16'hfe50);
        drive(0, 1'b0);
        drive(5, 1'b0);
    endtask

    task automatic t_mask();
        cpu_u.pulse(0, 7'h00);
        wr(8'h10, 32'h0001);
        wr(8'h0c, 32'h00c1);
        drive(0, 1'b1);
        drive(6, 1'b1);
        drive(7, 1'b1);
        quiet(4);
        rd_chk(8'h08, 32'h00c1);
        wr(8'h04, 32'h0081);
        rd_chk(8'h08, 32'h0041);
        drive(0, 1'b0);
        drive(7, 1'b0);
        rd_chk(8'h08, 32'h0040);
        wr(8'h0c, 32'h0);
        take_chk(1'b0, 16'hfe60);
        drive(6, 1'b0);
        wr(8'h10, 32'h0);
    endtask

    task automatic t_order();
        wr(8'h0c, 32'h7fff);
        wr(8'h00, 32'h1b);
        rd_chk(8'h00, 32'h1b);
        wr(8'h14, 32'h1);
        rd_chk(8'h14, 32'h1);
        wr(8'h0c, 32'h0);
        drive(1, 1'b1);
        drive(4, 1'b1);
        drive(14, 1'b1);
        quiet(4);
        `CHK(offer_level, 4'hd)
        cpu_u.pulse(0, 7'h00);
        take_chk(1'b0, 16'hfed0);
        `CHK(take_addr, 32'hfe0000d0)
        `CHK(status, 7'h3e)
        cpu_u.pulse(0, 7'h00);
        take_chk(1'b0, 16'hfe80);
        cpu_u.pulse(0, 7'h00);
        take_chk(1'b0, 16'hfe20);
        drive(1, 1'b0);
        drive(4, 1'b0);
        drive(14, 1'b0);
    endtask

    task automatic t_level();
        cpu_u.pulse(0, 7'h0f);
        drive(14, 1'b1);
        quiet(6);
        drive(3, 1'b1);
        take_chk(1'b0, 16'hfef0);
        `CHK(status, 7'h3f)
        cpu_u.pulse(0, 7'h00);
        take_chk(1'b0, 16'hfe20);
        drive(3, 1'b0);
        drive(14, 1'b0);
    endtask

    task automatic t_nmi();
        cpu_u.set_pc(32'h0abcdef0);
        cpu_u.pulse(0, 7'h10);
        @(posedge clk);
        nmi_int <= 1'b1;
        @(posedge clk);
        nmi_int <= 1'b0;
        take_chk(1'b1, 16'hffd0);
        `CHK(take_addr, 32'hffffffd0)
        `CHK(status, 7'h50)
        `CHK(fatal_save_pc, 32'h0abcdef0)
        `CHK(fatal_save_status, 7'h10)
        @(posedge clk);
        nmi_pin_n <= 1'b0;
        quiet(6);
        rd_chk(8'h18, 32'hd0);
        cpu_u.pulse(1, 7'h00);
        take_chk(1'b1, 16'hffd0);
        cpu_u.pulse(2, 7'h00);
        @(negedge clk);
        `CHK(status, 7'h10)
        @(posedge clk);
        nmi_pin_n <= 1'b1;
    endtask

    // ==========================================================
    // verdict and hang guard
    task automatic complete_run();
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_single();
        t_mask();
        t_order();
        t_level();
        t_nmi();
        complete_run();
    end
endmodule
`undef CHK
`default_nettype wire
